// ==== pkg/dpc_pkg.sv ====
package dpc_pkg;
  // Register offset on the serial control bus
  localparam logic [7:0] DPC_ADDR_DATAPATH = 8'h22;
  // Value after reset
  localparam logic [7:0] DPC_RESET_VALUE = 8'h00;
  // Field positions
  localparam int DPC_BIT_LOCK = 7;
  localparam int DPC_BIT_PASS = 6;
  localparam int DPC_BIT_POL = 5;
  localparam int DPC_BIT_REGEN = 4;
  localparam int DPC_BIT_OVR4 = 3;
  localparam int DPC_BIT_DEPTH18 = 2;
  localparam int DPC_BIT_INBAND = 1;
  localparam int DPC_BIT_EN4 = 0;
  // Mask of the fields loaded over the forward channel
  localparam logic [7:0] DPC_FWD_MASK = 8'h7F;
  // Width of the pixel bus
  localparam int DPC_PIX_W = 24;
  // Bus phase of a register access
  typedef enum logic [1:0] {
    DPC_IDLE = 2'b00,
    DPC_ACK = 2'b01
  } dpc_phase_t;
endpackage

// ==== verif/dpc_datapath_ctrl_tb.sv ====
module dpc_datapath_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import dpc_pkg::*;
  logic mclk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, reg_ack, fwd_valid;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [6:0] fwd_data;
  logic [23:0] pix_in = 24'h000000, pix_out;
  logic de_in = 0, aud_in = 0, rpc = 1, pix_valid, aud_out, prot, v18;
  logic inband, ch4;
  int err_total = 0;
  int checked = 0;
  // 25 MHz clock
  initial begin
    forever #20 mclk = ~mclk;
  end
  dpc_datapath_ctrl #(.PIX_W(24)) dpc_datapath_ctrl_inst (.mclk(mclk),
    .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .fwd_valid(fwd_valid), .fwd_data(fwd_data), .remote_prot_capable(rpc),
    .pix_in(pix_in), .de_in(de_in), .audio_pkt_in(aud_in),
    .pix_out(pix_out), .pix_valid(pix_valid), .audio_pkt_out(aud_out),
    .prot_enable(prot), .video_18bit(v18), .audio_inband(inband),
    .audio_4ch_en(ch4));
  dpc_fwd_model dpc_fwd_model_inst (.mclk(mclk), .fwd_valid(fwd_valid),
    .fwd_data(fwd_data));
  task chk(input string n, input logic [23:0] s, input logic [23:0] e);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %0h got %0h", n, e, s);
    end
  endtask
  // One register access; strobe is a single-cycle pulse
  task acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 0;
    reg_rd = 0;
    chk("ack", reg_ack, 1'b1);
  endtask
  // Write, then let derived outputs settle one more edge
  task wrs(input logic [7:0] d);
    acc(1, DPC_ADDR_DATAPATH, d);
    @(negedge mclk);
  endtask
  task t_reset;
    acc(0, DPC_ADDR_DATAPATH, 8'h00);
    chk("rst", reg_rdata, 8'h00);
    chk("prot", prot, 1'b1);
  endtask
  task t_fields;
    wrs(8'h0F);
    chk("v18", v18, 1'b1);
    chk("inb", inband, 1'b1);
    chk("ch4", ch4, 1'b1);
    // Unmapped write ignored; unmapped read after a nonzero read gives 0
    acc(1, 8'h30, 8'hFF);
    acc(0, DPC_ADDR_DATAPATH, 8'h00);
    chk("rdbk", reg_rdata, 8'h0F);
    acc(0, 8'h30, 8'h00);
    chk("unmap", reg_rdata, 8'h00);
    wrs(8'h07);
    chk("ch4", ch4, 1'b0);
    wrs(8'h08);
    chk("ch4", ch4, 1'b0);
    chk("v18", v18, 1'b0);
    chk("inb", inband, 1'b0);
  endtask
  // Forward load beats an earlier local write, unless locked
  task t_fwd;
    wrs(8'h55);
    dpc_fwd_model_inst.send(7'h2A);
    acc(0, DPC_ADDR_DATAPATH, 8'h00);
    chk("fwd", reg_rdata, 8'h2A);
    wrs(8'h80);
    dpc_fwd_model_inst.send(7'h7F);
    acc(0, DPC_ADDR_DATAPATH, 8'h00);
    chk("lock", reg_rdata, 8'h80);
  endtask
  task t_video;
    wrs(8'h20);
    chk("de", pix_valid, 1'b1);
    de_in = 1;
    @(negedge mclk);
    chk("de", pix_valid, 1'b0);
    wrs(8'h00);
    chk("de", pix_valid, 1'b1);
    de_in = 0;
    aud_in = 1;
    pix_in = 24'hA5C3E1;
    wrs(8'h40);
    chk("pass", pix_valid, 1'b1);
    chk("pix", pix_out, 24'hA5C3E1);
    chk("prot", prot, 1'b0);
    chk("aud", aud_out, 1'b0);
    rpc = 0;
    @(negedge mclk);
    chk("pass", pix_valid, 1'b0);
    chk("prot", prot, 1'b1);
    wrs(8'h10);
    chk("aud", aud_out, 1'b0);
    wrs(8'h00);
    chk("aud", aud_out, 1'b1);
  endtask
  // Local write and forward load in one cycle: forward wins bits 6..0
  task t_both;
    fork
      acc(1, DPC_ADDR_DATAPATH, 8'h80);
      dpc_fwd_model_inst.send(7'h15);
    join
    acc(0, DPC_ADDR_DATAPATH, 8'h00);
    chk("both", reg_rdata, 8'h95);
    chk("v18", v18, 1'b1);
  endtask
  task test_done;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog: the whole run needs only a few microseconds
  initial begin
    #100us;
    err_total++;
    test_done;
  end
  initial begin
    repeat (20) @(negedge mclk);
    rstn = 1;
    t_reset;
    t_fields;
    t_fwd;
    t_video;
    t_both;
    test_done;
  end
endmodule

// ==== verif/dpc_fwd_model.sv ====
// Remote serializer side: sends forward-channel config updates
module dpc_fwd_model (
  input wire logic mclk,
  output logic fwd_valid,
  output logic [6:0] fwd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    fwd_valid = 0;
    fwd_data = 7'h00;
  end
  // One-cycle update; data turns stale (inverted) once dropped
  task send(input logic [6:0] v);
    @(negedge mclk);
    fwd_valid = 1;
    fwd_data = v;
    @(negedge mclk);
    fwd_valid = 0;
    fwd_data = ~v;
  endtask
endmodule

// ==== verilog/dpc_cfg_store.sv ====
// One-byte configuration store with registered read data
module dpc_cfg_store
  import dpc_pkg::*;
(
  input wire logic mclk,
  input wire logic rstn,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data
);
  // Whole state of the store
  typedef struct packed {
    logic [7:0] value;
  } dpc_store_t;

  dpc_store_t cur;
  dpc_store_t next_cur;

  // Next value: write replaces the byte
  always_comb begin
    next_cur = cur;
    if (wr_en) begin
      next_cur.value = wr_data;
    end
  end

  // Synchronous reset to all zeros
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cur <= '{value: DPC_RESET_VALUE};
    end else begin
      cur <= next_cur;
    end
  end

  assign rd_data = cur.value;
endmodule

// ==== verilog/dpc_datapath_ctrl.sv ====
// Overview of operation
// - Lock bit set ignores forward channel loads
// - Lock clear: fields 6..0 load from serializer
// - Pass-through forwards pixels ignoring data enable
// - Pass-through disables protection, blocks packet audio
// - Pass-through inert without remote protection support
// - Polarity bit selects data-enable active level
// - Regen bit suppresses packet audio on pixels
// - Override clear forces four-channel audio off
// - Depth bit selects 18- or 24-bit video
// - Transport bit selects in-band or data-island
// - Enable bit switches four-channel audio reception
module dpc_datapath_ctrl
  import dpc_pkg::*;
#(
  parameter int PIX_W = DPC_PIX_W
)
(
  input wire logic mclk,
  input wire logic rstn,
  // Local register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_ack,
  // Forward-channel configuration update
  input wire logic fwd_valid,
  input wire logic [6:0] fwd_data,
  input wire logic remote_prot_capable,
  // Recovered video in
  input wire logic [PIX_W-1:0] pix_in,
  input wire logic de_in,
  input wire logic audio_pkt_in,
  // Video and control out
  output logic [PIX_W-1:0] pix_out,
  output logic pix_valid,
  output logic audio_pkt_out,
  output logic prot_enable,
  output logic video_18bit,
  output logic audio_inband,
  output logic audio_4ch_en
);
  // State of the block except the config byte, which dpc_cfg_store holds
  typedef struct packed {
    dpc_phase_t phase; // Register bus phase
    logic ack; // Registered acknowledge
    logic [7:0] rdata;
    logic [PIX_W-1:0] pix;
    logic valid;
    logic audio;
    logic prot;
    logic d18;
    logic inband;
    logic ch4;
  } dpc_state_t;

  dpc_state_t cur;
  dpc_state_t next_cur;
  logic [7:0] cfg;
  logic st_wr;
  logic [7:0] st_data;
  logic hit_wr;
  logic fwd_take;
  logic pass_eff;
  logic de_act;

  // Address decode, shared by the write strobe and the read mux
  function automatic logic addr_hit(input logic [7:0] a);
    logic hit;
    // Only one register is mapped; all else is a miss
    if (a == DPC_ADDR_DATAPATH) begin
      hit = 1'b1;
    end else begin
      hit = 1'b0;
    end
    return hit;
  endfunction

  // Local write decode
  assign hit_wr = reg_wr && addr_hit(reg_addr);
  // Forward load only while unlocked
  assign fwd_take = fwd_valid && !cfg[DPC_BIT_LOCK];

  // Merge: forward update overwrites low fields, local keeps lock bit
  always_comb begin
    st_wr = hit_wr || fwd_take;
    st_data = hit_wr ? reg_wdata : cfg;
    if (fwd_take) begin
      // Forward load beats a same-cycle local write
      st_data = {st_data[DPC_BIT_LOCK], fwd_data};
    end
  end

  dpc_cfg_store dpc_cfg_store_inst (
    .mclk(mclk),
    .rstn(rstn),
    .wr_en(st_wr),
    .wr_data(st_data),
    .rd_data(cfg)
  );

  // Pass-through only when the serializer supports protection
  assign pass_eff = cfg[DPC_BIT_PASS] && remote_prot_capable;
  // Active level of data enable
  assign de_act = cfg[DPC_BIT_POL] ? !de_in : de_in;

  // Next state of the datapath and bus
  always_comb begin
    next_cur = cur;
    // Bus phase: acknowledge follows every strobe by one cycle
    case (cur.phase)
      DPC_IDLE: begin
        if (reg_rd || reg_wr) begin
          next_cur.phase = DPC_ACK;
        end
      end
      DPC_ACK: begin
        // Back-to-back strobes keep the acknowledge phase
        if (!(reg_rd || reg_wr)) begin
          next_cur.phase = DPC_IDLE;
        end
      end
      default: begin
        // Unused code falls back to idle
        next_cur.phase = DPC_IDLE;
      end
    endcase
    // Acknowledge kept as its own flop so the port has no decode behind it
    next_cur.ack = (next_cur.phase == DPC_ACK);
    // Unmapped addresses read as zero
    if (reg_rd && addr_hit(reg_addr)) begin
      next_cur.rdata = cfg;
    end else if (reg_rd) begin
      next_cur.rdata = 8'h00;
    end
    next_cur.pix = pix_in;
    next_cur.valid = pass_eff || de_act;
    // Packet audio off in pass-through or regen mode
    next_cur.audio = audio_pkt_in && !pass_eff && !cfg[DPC_BIT_REGEN];
    next_cur.prot = !pass_eff;
    next_cur.d18 = cfg[DPC_BIT_DEPTH18];
    next_cur.inband = cfg[DPC_BIT_INBAND];
    // Four-channel audio gated by override
    next_cur.ch4 = cfg[DPC_BIT_OVR4] && cfg[DPC_BIT_EN4];
  end

  // State register, synchronous reset
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs straight from flip-flops
  assign reg_rdata = cur.rdata;
  assign reg_ack = cur.ack;
  assign pix_out = cur.pix;
  assign pix_valid = cur.valid;
  assign audio_pkt_out = cur.audio;
  assign prot_enable = cur.prot;
  assign video_18bit = cur.d18;
  assign audio_inband = cur.inband;
  assign audio_4ch_en = cur.ch4;

  chk_lock_holds: assert property (@(posedge mclk) disable iff (!rstn)
    cfg[DPC_BIT_LOCK] && fwd_valid && !hit_wr |=> $stable(cfg))
    else $error("locked register changed by forward load");
  chk_fwd_loads: assert property (@(posedge mclk) disable iff (!rstn)
    fwd_take |=> cfg[6:0] == $past(fwd_data))
    else $error("forward load not applied");
  chk_pass_valid: assert property (@(posedge mclk) disable iff (!rstn)
    pass_eff |=> pix_valid)
    else $error("pass-through did not force valid");
  chk_pass_blocks: assert property (@(posedge mclk) disable iff (!rstn)
    pass_eff |=> !audio_pkt_out && !prot_enable)
    else $error("pass-through left audio or protection on");
  chk_no_support: assert property (@(posedge mclk) disable iff (!rstn)
    !remote_prot_capable |=> prot_enable)
    else $error("pass-through acted without support");
  chk_de_polar: assert property (@(posedge mclk) disable iff (!rstn)
    !pass_eff && cfg[DPC_BIT_POL] |=> pix_valid == !$past(de_in))
    else $error("data enable polarity wrong");
  chk_regen_mute: assert property (@(posedge mclk) disable iff (!rstn)
    cfg[DPC_BIT_REGEN] |=> !audio_pkt_out)
    else $error("audio not suppressed in regen mode");
  chk_ovr_off: assert property (@(posedge mclk) disable iff (!rstn)
    !cfg[DPC_BIT_OVR4] |=> !audio_4ch_en)
    else $error("four-channel audio on without override");
  chk_depth_sel: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> video_18bit == $past(cfg[DPC_BIT_DEPTH18]))
    else $error("video depth mismatch");
  chk_transport: assert property (@(posedge mclk) disable iff (!rstn)
    1'b1 |=> audio_inband == $past(cfg[DPC_BIT_INBAND]))
    else $error("transport select mismatch");
  chk_en_4ch: assert property (@(posedge mclk) disable iff (!rstn)
    cfg[DPC_BIT_OVR4] |=> audio_4ch_en == $past(cfg[DPC_BIT_EN4]))
    else $error("four-channel enable mismatch");
  chk_fwd_wins: assert property (@(posedge mclk) disable iff (!rstn)
    fwd_take && hit_wr |=> cfg == {$past(reg_wdata[7]), $past(fwd_data)})
    else $error("local write beat forward load");

  // Locked register still takes local writes as they are
  chk_local_kept: assert property (@(posedge mclk) disable iff (!rstn)
    cfg[DPC_BIT_LOCK] && hit_wr |=> cfg == $past(reg_wdata))
    else $error("local write lost while locked");
  chk_fwd_keeps_lock: assert property (@(posedge mclk) disable iff (!rstn)
    fwd_take && !hit_wr |=> cfg[DPC_BIT_LOCK] == $past(cfg[DPC_BIT_LOCK]))
    else $error("forward load touched the lock bit");
  chk_reset_zero: assert property (@(posedge mclk)
    $rose(rstn) |-> cfg == DPC_RESET_VALUE)
    else $error("register not zero after reset");

  // Main scenarios reached
  cov_lock_block: cover property (@(posedge mclk) cfg[7] && fwd_valid);
  cov_pass: cover property (@(posedge mclk) pass_eff ##1 pix_valid);
  cov_both_wr: cover property (@(posedge mclk) fwd_take && hit_wr);
  cov_fwd_load: cover property (@(posedge mclk) fwd_take && !hit_wr);
  cov_de_low: cover property (@(posedge mclk) cfg[DPC_BIT_POL] && !de_in);
endmodule
